// file: hdl/wmr_pkg.sv
// constants for the remote wake and interrupt mask register bank
package wmr_pkg;

  localparam int NREG = 8;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_ADDR_LO = 6'h15;
  localparam logic [5:0] IDX_ADDR_MD = 6'h16;
  localparam logic [5:0] IDX_ADDR_HI = 6'h17;
  localparam logic [5:0] IDX_PW_LO   = 6'h18;
  localparam logic [5:0] IDX_PW_MD   = 6'h19;
  localparam logic [5:0] IDX_PW_HI   = 6'h1a;
  localparam logic [5:0] IDX_CTRL    = 6'h1b;
  localparam logic [5:0] IDX_MASK    = 6'h1c;
  localparam logic [5:0] IDX_STAT    = 6'h1d;
  localparam logic [5:0] IDX_SRST    = 6'h1e;

  // values after reset
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_CTRL = 16'h0ff0;

  // writable bits; all others are reserved
  localparam logic [15:0] WM_FULL = 16'hffff;
  localparam logic [15:0] WM_CTRL = 16'hcff1;
  localparam logic [15:0] WM_IRQ  = 16'h301f;

  localparam logic [15:0] RST_VAL [NREG] = '{RST_ZERO, RST_ZERO, RST_ZERO,
    RST_ZERO, RST_ZERO, RST_ZERO, RST_CTRL, RST_ZERO};
  localparam logic [15:0] WMASK [NREG] = '{WM_FULL, WM_FULL, WM_FULL,
    WM_FULL, WM_FULL, WM_FULL, WM_CTRL, WM_IRQ};

  // control word fields
  localparam int CTRL_PW_EN  = 15;
  localparam int CTRL_PW_LEN = 14;
  localparam int CTRL_REP_LS = 8;
  localparam int CTRL_EDG_LS = 5;
  localparam int CTRL_CLKO   = 4;
  localparam int CTRL_CMOS   = 0;

  // interrupt mask and status bits
  localparam int IRQ_RXF  = 13;
  localparam int IRQ_TXF  = 12;
  localparam int IRQ_SWAP = 4;
  localparam int IRQ_LNK  = 3;
  localparam int IRQ_QT   = 2;
  localparam int IRQ_SLP  = 1;
  localparam int IRQ_WERR = 0;

  localparam int SRST_BIT = 0;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : wmr_pkg

// file: hdl/wmr_regs.sv
// remote wake address, password, control and interrupt mask registers

// Function
// R01: station address held in low, mid, high 16-bit words, reset zero
// R02: wake password held in low, mid, high 16-bit words, reset zero
// R03: control bit 15 enables password check, bit 14 picks four bytes
// R04: control bits 11:8 give address repeat count minus one, reset ones
// R05: control bits 7:5 set pad edge rate, reset to fastest
// R06: control bit 4 enables reference clock output, reset one
// R07: mask bits 13 and 12 enable rx and tx fifo fault interrupts
// R08: mask bit 4 enables timing role swap done interrupt
// R09: mask bits 3 to 0 enable the four energy saving interrupts
// R10: sticky bits survive a software reset, cleared by hardware reset only
// R11: reserved bits read zero and ignore writes
module wmr_regs
  import wmr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              aclken,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [15:0]       irq_event,
  output logic [47:0]            wake_station_addr,
  output logic [47:0]            wake_password,
  output logic                   pw_check_en,
  output logic                   pw_len_four,
  output logic [4:0]             addr_repeat_count,
  output logic [2:0]             mac_pad_edge_rate,
  output logic                   reference_clock_output_en,
  output logic                   irq_pin_cmos_drive,
  output logic                   management_interrupt_pin
);

  logic [15:0]       regs [NREG];
  logic [15:0]       stat;
  logic              soft_rst;
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [15:0]       w_data_q;
  logic [1:0]        w_strb_q;
  logic              do_write;
  logic [5:0]        w_idx;
  logic [5:0]        r_idx;
  logic              w_in_bank;
  logic              r_in_bank;
  logic [2:0]        w_slot;
  logic [2:0]        r_slot;
  logic [15:0]       ev_valid;
  logic [15:0]       w1c;
  logic [15:0]       next_rd;
  logic              next_rd_ok;

  // write and read channel handshakes
  assign awready = aclken && !aw_held && !bvalid;
  assign wready  = aclken && !w_held && !bvalid;
  assign arready = aclken && !rvalid;
  assign do_write = aclken && aw_held && w_held && !bvalid;

  // index decode; the two low address bits are ignored
  assign w_idx = 6'(aw_addr_q[ADDR_W-1:2]);
  assign r_idx = 6'(araddr[ADDR_W-1:2]);
  assign w_in_bank = (w_idx >= IDX_ADDR_LO) && (w_idx <= IDX_MASK);
  assign r_in_bank = (r_idx >= IDX_ADDR_LO) && (r_idx <= IDX_MASK);
  assign w_slot = 3'(w_idx - IDX_ADDR_LO);
  assign r_slot = 3'(r_idx - IDX_ADDR_LO);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      aw_addr_q <= '0;
    end else if (aclken) begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held   <= 1'b0;
      w_data_q <= RST_ZERO;
      w_strb_q <= 2'h0;
    end else if (aclken) begin
      if (wvalid && wready) begin
        w_held   <= 1'b1;
        w_data_q <= wdata[15:0];
        w_strb_q <= wstrb[1:0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response; unmapped indices answer with slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (aclken) begin
      if (do_write) begin
        bvalid <= 1'b1;
        if (w_in_bank || w_idx == IDX_STAT || w_idx == IDX_SRST) begin
          bresp <= RESP_OKAY;
        end else begin
          bresp <= RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // configuration storage, byte lanes 0 and 1 only
  for (genvar g = 0; g < NREG; g++) begin : g_reg
    logic [15:0] next_val;
    assign next_val[7:0]  = w_strb_q[0] ? w_data_q[7:0] : regs[g][7:0];
    assign next_val[15:8] = w_strb_q[1] ? w_data_q[15:8] : regs[g][15:8];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        regs[g] <= RST_VAL[g]; // R01 R02 R10
      end else if (aclken && do_write && w_in_bank && w_slot == 3'(g)) begin
        regs[g] <= (regs[g] & ~WMASK[g]) | (next_val & WMASK[g]); // R11
      end
    end
  end

  // software reset pulse; it leaves the sticky registers alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_rst <= 1'b0;
    end else if (aclken) begin
      soft_rst <= do_write && w_idx == IDX_SRST && w_strb_q[0]
                  && w_data_q[SRST_BIT]; // R10
    end
  end

  // interrupt status: sticky events, write one to clear, set wins
  assign ev_valid = irq_event & WM_IRQ;
  assign w1c = (do_write && w_idx == IDX_STAT)
             ? ({w_strb_q[1] ? w_data_q[15:8] : 8'h00,
                 w_strb_q[0] ? w_data_q[7:0] : 8'h00} & WM_IRQ)
             : 16'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat <= RST_ZERO;
    end else if (aclken) begin
      if (soft_rst) begin
        stat <= ev_valid; // R10
      end else begin
        stat <= (stat & ~w1c) | ev_valid;
      end
    end
  end

  // interrupt pin gated by the mask register
  assign management_interrupt_pin = |(stat & regs[7]); // R07 R08 R09

  // read data, taken from flops on the address handshake
  always_comb begin
    next_rd    = RST_ZERO;
    next_rd_ok = 1'b1;
    if (r_in_bank) begin
      next_rd = regs[r_slot] & WMASK[r_slot]; // R11
    end else if (r_idx == IDX_STAT) begin
      next_rd = stat;
    end else if (r_idx == IDX_SRST) begin
      next_rd = RST_ZERO;
    end else begin
      next_rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (aclken) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= {16'h0000, next_rd};
        rresp  <= next_rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // configuration outputs
  assign wake_station_addr = {regs[2], regs[1], regs[0]}; // R01
  assign wake_password     = {regs[5], regs[4], regs[3]}; // R02
  assign pw_check_en       = regs[6][CTRL_PW_EN]; // R03
  assign pw_len_four       = regs[6][CTRL_PW_LEN]; // R03
  assign addr_repeat_count = {1'b0, regs[6][CTRL_REP_LS +: 4]} + 5'h01; // R04
  assign mac_pad_edge_rate = regs[6][CTRL_EDG_LS +: 3]; // R05
  assign reference_clock_output_en = regs[6][CTRL_CLKO]; // R06
  assign irq_pin_cmos_drive = regs[6][CTRL_CMOS];

  // checks
  logic full_w;
  assign full_w = do_write && w_strb_q == 2'h3;

  addr_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // R01
    full_w && w_idx == IDX_ADDR_HI
    |=> wake_station_addr[47:32] == $past(w_data_q))
    else $error("station address high word not written");

  pw_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // R02
    full_w && w_idx == IDX_PW_LO
    |=> wake_password[15:0] == $past(w_data_q))
    else $error("password low word not written");

  pw_ctrl_a: assert property (@(posedge aclk) disable iff (!aresetn) // R03
    full_w && w_idx == IDX_CTRL
    |=> pw_check_en == $past(w_data_q[15]) && pw_len_four == $past(w_data_q[14]))
    else $error("password control bits not written");

  reset_ctrl_a: assert property (@(posedge aclk) // R04
    $rose(aresetn) |-> addr_repeat_count == 5'h10 && mac_pad_edge_rate == 3'h7
    && reference_clock_output_en && !pw_check_en)
    else $error("control word reset value wrong");

  rate_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // R05
    full_w && w_idx == IDX_CTRL
    |=> mac_pad_edge_rate == $past(w_data_q[7:5])
    && addr_repeat_count == {1'b0, $past(w_data_q[11:8])} + 5'h01)
    else $error("edge rate or repeat count not written");

  clko_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // R06
    full_w && w_idx == IDX_CTRL
    |=> reference_clock_output_en == $past(w_data_q[4]))
    else $error("clock output enable not written");

  irq_raise_a: assert property (@(posedge aclk) disable iff (!aresetn) // R07
    aclken && |(ev_valid & regs[7]) ##0 !(do_write && w_slot == 3'h7)
    |=> management_interrupt_pin)
    else $error("unmasked event gave no interrupt");

  irq_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn) // R09
    regs[7] == 16'h0000 |-> !management_interrupt_pin)
    else $error("interrupt raised with all sources masked");

  swap_mask_a: assert property (@(posedge aclk) disable iff (!aresetn) // R08
    full_w && w_idx == IDX_MASK
    |=> regs[7][IRQ_SWAP] == $past(w_data_q[4]))
    else $error("swap interrupt mask not written");

  set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    aclken && ev_valid != 16'h0000 |=> (stat & $past(ev_valid)) == $past(ev_valid))
    else $error("event lost against clear");

  sticky_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    soft_rst && !do_write |=> $stable(wake_station_addr) && $stable(wake_password))
    else $error("soft reset disturbed sticky bits");

  reserved_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    regs[6][13:12] == 2'h0 && regs[6][3:1] == 3'h0 && regs[7][15:14] == 2'h0
    && regs[7][11:5] == 7'h00)
    else $error("reserved bit set");

  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

  addr_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // R01
    full_w && w_idx == IDX_ADDR_LO
    |=> wake_station_addr[15:0] == $past(w_data_q))
    else $error("station address low word not written");

  addr_mid_a: assert property (@(posedge aclk) disable iff (!aresetn) // R01
    full_w && w_idx == IDX_ADDR_MD
    |=> wake_station_addr[31:16] == $past(w_data_q))
    else $error("station address middle word not written");

  pw_mid_a: assert property (@(posedge aclk) disable iff (!aresetn) // R02
    full_w && w_idx == IDX_PW_MD
    |=> wake_password[31:16] == $past(w_data_q))
    else $error("password middle word not written");

  pw_high_a: assert property (@(posedge aclk) disable iff (!aresetn) // R02
    full_w && w_idx == IDX_PW_HI
    |=> wake_password[47:32] == $past(w_data_q))
    else $error("password high word not written");

  lane_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // R03
    do_write && w_idx == IDX_CTRL && w_strb_q == 2'h1
    |=> pw_check_en == $past(pw_check_en) && pw_len_four == $past(pw_len_four))
    else $error("unstrobed control byte changed");

  fifo_mask_a: assert property (@(posedge aclk) disable iff (!aresetn) // R07
    full_w && w_idx == IDX_MASK
    |=> regs[7][IRQ_RXF] == $past(w_data_q[13]) && regs[7][IRQ_TXF] == $past(w_data_q[12]))
    else $error("fifo interrupt mask not written");

  eee_mask_a: assert property (@(posedge aclk) disable iff (!aresetn) // R09
    full_w && w_idx == IDX_MASK
    |=> regs[7][3:0] == $past(w_data_q[3:0]))
    else $error("energy saving interrupt mask not written");

  srst_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    aclken && soft_rst |=> stat == $past(ev_valid))
    else $error("soft reset did not clear status");

  hw_reset_a: assert property (@(posedge aclk) // R10
    !aresetn |=> wake_station_addr == 48'h0 && wake_password == 48'h0
    && regs[7] == RST_ZERO && stat == RST_ZERO)
    else $error("hardware reset left a register set");

  read_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped early");

  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> bvalid)
    else $error("write commit gave no response");

  read_resp_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    arvalid && arready |=> rvalid && rdata[31:16] == 16'h0000)
    else $error("read answer late or upper half set");

  write_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    full_w && w_idx == IDX_CTRL ##1 bvalid && bready);
  read_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready && r_idx == IDX_MASK ##1 rvalid);
  irq_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(management_interrupt_pin));
  srst_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    soft_rst && stat != 16'h0000);
  lane_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    do_write && w_strb_q == 2'h1);

endmodule : wmr_regs

// file: testbench/wmr_regs_tb.sv
// self-checking bench for the remote wake and interrupt mask register bank
module wmr_regs_tb
  import wmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        aclk;
  logic        aresetn;
  logic        aclken;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [15:0] irq_event;
  logic [47:0] w_addr;
  logic [47:0] w_pw;
  logic        pw_en;
  logic        pw_four;
  logic [4:0]  rep_cnt;
  logic [2:0]  edge_rate;
  logic        clk_out_en;
  logic        cmos_drv;
  logic        irq_pin;
  int          mismatches;
  int          checks;
  int          cycles;
  int          seed;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [15:0] exp_reg [NREG];
  logic [15:0] v [NREG];
  localparam int IB [7] = '{13, 12, 4, 3, 2, 1, 0};

  wmr_regs u_dut (.aclk(aclk), .aresetn(aresetn), .aclken(aclken), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq_event(irq_event),
    .wake_station_addr(w_addr), .wake_password(w_pw), .pw_check_en(pw_en),
    .pw_len_four(pw_four), .addr_repeat_count(rep_cnt), .mac_pad_edge_rate(edge_rate),
    .reference_clock_output_en(clk_out_en), .irq_pin_cmos_drive(cmos_drv),
    .management_interrupt_pin(irq_pin));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic print_verdict;
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  function automatic logic [7:0] ba(input int idx);
    return {6'(idx), 2'b00};
  endfunction : ba

  task automatic wr(input int idx, input logic [15:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge aclk);
    bq.push_back(r);
    awaddr <= ba(idx);
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
  endtask : wr

  task automatic rd(input int idx, input logic [15:0] e, input logic [1:0] r);
    logic ha, hr;
    hr = 1'b0;
    @(posedge aclk);
    rq.push_back({r, 16'h0000, e});
    araddr <= ba(idx);
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end
  endtask : rd

  task automatic rd_all;
    for (int i = 0; i < NREG; i++) rd(IDX_ADDR_LO + i, exp_reg[i], RESP_OKAY);
  endtask : rd_all

  task automatic pulse(input logic [15:0] e, input logic pin);
    @(posedge aclk);
    irq_event <= e;
    @(posedge aclk);
    irq_event <= 16'h0000;
    @(negedge aclk);
    chk("irq_pin", irq_pin, pin);
  endtask : pulse

  always @(negedge aclk) begin
    if (aresetn && bvalid && bready) chk("bresp", bresp, bq.pop_front());
    if (aresetn && rvalid && rready) chk("read", {rresp, rdata}, rq.pop_front());
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    seed = 32'h793d3049;
    {aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, irq_event} = '0;
    aclken = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    exp_reg = RST_VAL;
    rd_all();
    @(negedge aclk);
    chk("repeat", rep_cnt, 5'd16);
    chk("edge", edge_rate, 3'h7);
    chk("reference_clock_output", clk_out_en, 1'b1);
    chk("pw_en", {pw_en, pw_four}, 2'b00);
    chk("cmos", cmos_drv, 1'b0);
    for (int i = 0; i < NREG; i++) begin
      v[i] = 16'($random(seed));
      wr(IDX_ADDR_LO + i, v[i], 4'h3, RESP_OKAY);
      exp_reg[i] = v[i] & WMASK[i];
    end
    rd_all();
    @(negedge aclk);
    chk("addr", w_addr, {v[2], v[1], v[0]});
    chk("pw", w_pw, {v[5], v[4], v[3]});
    chk("pw_ctl", {pw_en, pw_four}, v[6][15:14]);
    chk("repeat", rep_cnt, {1'b0, v[6][11:8]} + 5'd1);
    chk("edge", edge_rate, v[6][7:5]);
    chk("reference_clock_output", clk_out_en, v[6][4]);
    chk("cmos", cmos_drv, v[6][0]);
    wr(IDX_CTRL, 16'h0000, 4'h3, RESP_OKAY);
    wr(IDX_CTRL, 16'hffff, 4'h1, RESP_OKAY);
    exp_reg[6] = 16'h00f1;
    rd(IDX_CTRL, 16'h00f1, RESP_OKAY);
    @(negedge aclk);
    chk("repeat", rep_cnt, 5'd1);
    wr(0, 16'hffff, 4'h3, RESP_SLVERR);
    rd(0, 16'h0000, RESP_SLVERR);
    for (int k = 0; k < 7; k++) begin
      exp_reg[7] = 16'h0001 << IB[k];
      wr(IDX_MASK, exp_reg[7], 4'h3, RESP_OKAY);
      pulse(~exp_reg[7], 1'b0);
      pulse(exp_reg[7], 1'b1);
      wr(IDX_STAT, 16'hffff, 4'h3, RESP_OKAY);
      @(negedge aclk);
      chk("irq_clr", irq_pin, 1'b0);
    end
    @(posedge aclk);
    aclken <= 1'b0;
    irq_event <= 16'h0001;
    @(posedge aclk);
    irq_event <= 16'h0000;
    aclken <= 1'b1;
    @(negedge aclk);
    chk("irq_frozen", irq_pin, 1'b0);
    exp_reg[7] = 16'h301f;
    wr(IDX_MASK, 16'hffff, 4'h3, RESP_OKAY);
    pulse(16'hffff, 1'b1);
    rd(IDX_STAT, 16'h301f, RESP_OKAY);
    wr(IDX_SRST, 16'h0001, 4'h3, RESP_OKAY);
    @(negedge aclk);
    chk("irq_srst", irq_pin, 1'b0);
    rd(IDX_STAT, 16'h0000, RESP_OKAY);
    rd(IDX_SRST, 16'h0000, RESP_OKAY);
    rd_all();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    exp_reg = RST_VAL;
    rd_all();
    repeat (3) @(posedge aclk);
    print_verdict();
  end
endmodule : wmr_regs_tb
